// ---- byte_fifo.v ----
`timescale 1ns/1ps
module byte_fifo #(
    parameter WIDTH    = 8,
    parameter DEPTH    = 4,
    parameter PTR_BITS = 2
) (
    // clock and reset
    input  wire             mclk_i,
    input  wire             reset_i,
    // filling side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // draining side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0]  mem [0:DEPTH-1];
    reg [PTR_BITS-1:0] wr_ptr;
    reg [PTR_BITS-1:0] rd_ptr;
    reg [PTR_BITS:0]   count;
    wire push;
    wire pop;

    assign in_ready_o  = (count != DEPTH[PTR_BITS:0]);
    assign out_valid_o = (count != {(PTR_BITS+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;

    // storage has no reset; contents only matter while counted
    always @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers and fill level
    always @(posedge mclk_i) begin
        if (reset_i) begin
            wr_ptr <= {PTR_BITS{1'b0}};
            rd_ptr <= {PTR_BITS{1'b0}};
            count  <= {(PTR_BITS+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // byte_fifo

// ---- dual_spi_slave_front_end.v ----
`timescale 1ns/1ps
`include "spi_front_map.vh"

// How it works
// - falling edge of either select input starts an access
// - both selects high deselects device; both serial outputs released
// - falling edge on other select takes over a stuck-low port
// - only mode 3: clock idles high, sample rising, shift falling
// - serial input of active port sampled on its clock rising edge
// - serial output changes after each falling clock edge
// - outputs released unless actively returning data; always released in standby
// - interrupt outputs open drain, active low, only pull low
// - selected indicator low while selected, high at either select rise
// - no-operation drives cascade low, ignores rest; high at select rise
// - port enable low keeps both interrupt outputs released
// - optionally port enable low also floats both 8-bit port drivers
// - only one port carries an access at a time
// - software addressing: first byte matched to address pins, else standby
// - all-zero address pins: hardware addressing, no address byte
// - eight-bit address lets up to 255 devices share a bus
// - no-operation opcode is the all-zero byte
// - after no-operation, input discarded, output released until deselect
// - opcode is second byte in software mode, first in hardware mode
// - select rising mid-byte flags a failed command by a one-cycle pulse
module dual_spi_slave_front_end (
    // clock and reset
    input  wire       mclk_i,
    input  wire       reset_i,
    // first serial port
    input  wire       select_in_first_i,
    input  wire       serial_clock_first_i,
    input  wire       serial_in_first_i,
    output wire       serial_out_first_o,
    output wire       serial_out_first_oe_o,
    // second serial port
    input  wire       select_in_second_i,
    input  wire       serial_clock_second_i,
    input  wire       serial_in_second_i,
    output wire       serial_out_second_o,
    output wire       serial_out_second_oe_o,
    // addressing and port enable
    input  wire [7:0] slave_address_pins_i,
    input  wire       port_enable_in_i,
    input  wire       port_float_option_i,
    // status outputs, active low
    output reg        selected_indicator_o,
    output reg        cascade_select_out_o,
    // open-drain interrupts: output always low, enable pulls
    output wire       interrupt_out_first_o,
    output wire       interrupt_out_first_oe_o,
    output wire       interrupt_out_second_o,
    output wire       interrupt_out_second_oe_o,
    // request from interrupt controller and port driver gate
    input  wire       irq_request_first_i,
    input  wire       irq_request_second_i,
    output wire       port_drivers_enable_o,
    // received bytes toward the command decoder
    output wire       rx_valid_o,
    input  wire       rx_ready_i,
    output wire [7:0] rx_data_o,
    output reg        rx_is_opcode_o,
    // byte to return and failed-command pulse
    input  wire [7:0] tx_data_i,
    input  wire       tx_enable_i,
    output reg        failed_command_o
);
    // two-stage synchronisers for all pin inputs
    reg [2:0] sync1_first;
    reg [2:0] sync2_first;
    reg [2:0] sync1_second;
    reg [2:0] sync2_second;
    reg [1:0] sync1_misc;
    reg [1:0] sync2_misc;
    reg [7:0] addr_sync1;
    reg [7:0] addr_sync2;
    // history for edge detection, read from second stage only
    reg       sel_first_d;
    reg       sel_second_d;
    reg       clk_first_d;
    reg       clk_second_d;
    // sequencer
    reg [2:0] state;
    reg [2:0] next_state;
    reg       active_port;  // 0 first, 1 second
    reg [3:0] bit_count;
    reg [7:0] shift_in;
    reg [7:0] shift_out;
    reg       out_bit;
    reg       driving;
    // fifo handshake
    reg       push_valid;
    reg [7:0] push_data;
    wire      push_ready;
    wire      fifo_valid;

    wire sel_first    = sync2_first[0];
    wire clk_first    = sync2_first[1];
    wire din_first    = sync2_first[2];
    wire sel_second   = sync2_second[0];
    wire clk_second   = sync2_second[1];
    wire din_second   = sync2_second[2];
    wire port_enable  = sync2_misc[0];
    wire float_option = sync2_misc[1];

    wire fall_first   = sel_first_d & ~sel_first;
    wire fall_second  = sel_second_d & ~sel_second;
    wire rise_any     = (~sel_first_d & sel_first) | (~sel_second_d & sel_second);
    wire both_high    = sel_first & sel_second;
    // mode 3: sample on rising, shift on falling, of active port only
    wire act_clk      = active_port ? clk_second : clk_first;
    wire act_clk_d    = active_port ? clk_second_d : clk_first_d;
    wire act_din      = active_port ? din_second : din_first;
    wire sck_rise     = ~act_clk_d & act_clk;
    wire sck_fall     = act_clk_d & ~act_clk;
    wire [7:0] byte_in = {shift_in[6:0], act_din};
    wire byte_done    = sck_rise & (bit_count == (`BITS_PER_BYTE - 4'h1));
    wire hw_mode      = (addr_sync2 == `HARDWARE_ADDRESS);
    wire in_access    = (state != `ST_IDLE);

    // synchronise every pin input through two flip-flops
    always @(posedge mclk_i) begin
        if (reset_i) begin
            sync1_first  <= 3'h7;
            sync2_first  <= 3'h7;
            sync1_second <= 3'h7;
            sync2_second <= 3'h7;
            sync1_misc   <= 2'h0;
            sync2_misc   <= 2'h0;
            addr_sync1   <= 8'h00;
            addr_sync2   <= 8'h00;
        end else begin
            sync1_first  <= {serial_in_first_i, serial_clock_first_i, select_in_first_i};
            sync2_first  <= sync1_first;
            sync1_second <= {serial_in_second_i, serial_clock_second_i, select_in_second_i};
            sync2_second <= sync1_second;
            sync1_misc   <= {port_float_option_i, port_enable_in_i};
            sync2_misc   <= sync1_misc;
            addr_sync1   <= slave_address_pins_i;
            addr_sync2   <= addr_sync1;
        end
    end

    // edge history; idle-high reset keeps a start-up from faking edges
    always @(posedge mclk_i) begin
        if (reset_i) begin
            sel_first_d  <= 1'b1;
            sel_second_d <= 1'b1;
            clk_first_d  <= 1'b1;
            clk_second_d <= 1'b1;
        end else begin
            sel_first_d  <= sel_first;
            sel_second_d <= sel_second;
            clk_first_d  <= clk_first;
            clk_second_d <= clk_second;
        end
    end

    // next state of the byte sequencer
    always @* begin
        next_state = state;
        case (state)
            `ST_IDLE: begin
                next_state = hw_mode ? `ST_OPCODE : `ST_ADDRESS;
            end
            `ST_ADDRESS: begin
                if (byte_done) begin
                    // all eight pins compared, so 255 nonzero addresses usable
                    next_state = (byte_in == addr_sync2) ? `ST_OPCODE : `ST_STANDBY;
                end
            end
            `ST_OPCODE: begin
                if (byte_done) begin
                    next_state = (byte_in == `OPCODE_NO_OPERATION) ? `ST_STANDBY : `ST_DATA;
                end
            end
            `ST_DATA: begin
                next_state = `ST_DATA;
            end
            `ST_STANDBY: begin
                next_state = `ST_STANDBY;
            end
            default: begin
                next_state = `ST_IDLE;
            end
        endcase
    end

    // port selection, start and end of access
    always @(posedge mclk_i) begin
        if (reset_i) begin
            state       <= `ST_IDLE;
            active_port <= 1'b0;
            bit_count   <= 4'h0;
            shift_in    <= 8'h00;
        end else if (fall_first | fall_second) begin
            // newest falling select wins, overriding a stuck-low port
            active_port <= fall_second & ~fall_first;
            state       <= hw_mode ? `ST_OPCODE : `ST_ADDRESS;
            bit_count   <= 4'h0;
            shift_in    <= 8'h00;
        end else if (both_high | rise_any) begin
            state     <= `ST_IDLE;
            bit_count <= 4'h0;
            shift_in  <= 8'h00;
        end else if (in_access & sck_rise & (state != `ST_STANDBY)) begin
            shift_in  <= byte_in;
            bit_count <= byte_done ? 4'h0 : bit_count + 4'h1;
            state     <= next_state;
        end
    end

    // hand finished bytes to the fifo; a full fifo drops bytes without a flag
    always @(posedge mclk_i) begin
        if (reset_i) begin
            push_valid     <= 1'b0;
            push_data      <= 8'h00;
            rx_is_opcode_o <= 1'b0;
        end else begin
            push_valid <= 1'b0;
            if (in_access & byte_done & ((state == `ST_OPCODE) | (state == `ST_DATA))
                & ~both_high & ~rise_any & ~fall_first & ~fall_second) begin
                push_valid     <= (state == `ST_DATA) | (byte_in != `OPCODE_NO_OPERATION);
                push_data      <= byte_in;
                rx_is_opcode_o <= (state == `ST_OPCODE);
            end
        end
    end

    // transmit shifter: load on each byte's first falling edge, change only after falling edge
    always @(posedge mclk_i) begin
        if (reset_i) begin
            shift_out <= 8'h00;
            out_bit   <= 1'b1;
            driving   <= 1'b0;
        end else if (~in_access | (state == `ST_STANDBY) | both_high) begin
            driving <= 1'b0;
        end else if (sck_fall) begin
            if (bit_count == 4'h0) begin
                shift_out <= {tx_data_i[6:0], 1'b0};
                out_bit   <= tx_data_i[7];
                driving   <= tx_enable_i & (state == `ST_DATA);
            end else begin
                shift_out <= {shift_out[6:0], 1'b0};
                out_bit   <= shift_out[7];
            end
        end
    end

    // indicator and cascade outputs, plus failed-command pulse
    always @(posedge mclk_i) begin
        if (reset_i) begin
            selected_indicator_o <= 1'b1;
            cascade_select_out_o <= 1'b1;
            failed_command_o     <= 1'b0;
        end else begin
            // a partial byte at select rise means an incomplete command
            failed_command_o <= rise_any & in_access & (state != `ST_STANDBY)
                                & (bit_count != 4'h0);
            if (rise_any | both_high) begin
                selected_indicator_o <= 1'b1;
                cascade_select_out_o <= 1'b1;
            end else begin
                if ((state == `ST_OPCODE) | (state == `ST_DATA) | (fall_first | fall_second) & hw_mode) begin
                    selected_indicator_o <= 1'b0;
                end
                if (byte_done & (state == `ST_OPCODE) & (byte_in == `OPCODE_NO_OPERATION)) begin
                    cascade_select_out_o <= 1'b0;
                    selected_indicator_o <= 1'b0;
                end
            end
        end
    end

    // only the active port's output is enabled
    assign serial_out_first_o     = out_bit;
    assign serial_out_second_o    = out_bit;
    assign serial_out_first_oe_o  = driving & ~active_port;
    assign serial_out_second_oe_o = driving & active_port;

    // open drain: data pin always low, enable only to pull
    assign interrupt_out_first_o     = 1'b0;
    assign interrupt_out_second_o    = 1'b0;
    assign interrupt_out_first_oe_o  = irq_request_first_i & port_enable;
    assign interrupt_out_second_oe_o = irq_request_second_i & port_enable;
    assign port_drivers_enable_o     = port_enable | ~float_option;

    assign rx_valid_o = fifo_valid;

    // received bytes queue; decoder back-pressure fills it
    byte_fifo #(
        .WIDTH    (`RX_FIFO_WIDTH),
        .DEPTH    (`RX_FIFO_DEPTH),
        .PTR_BITS (`RX_FIFO_PTR_BITS)
    ) u_rx_fifo (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );
endmodule // dual_spi_slave_front_end

// ---- dual_spi_slave_front_end_sva.sv ----
`timescale 1ns/1ps
// pin-level checks of the front end
module dual_spi_slave_front_end_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // serial side
    input wire logic select_in_first_i,
    input wire logic select_in_second_i,
    input wire logic serial_out_first_oe_o,
    input wire logic serial_out_second_oe_o,
    // gating and status
    input wire logic port_enable_in_i,
    input wire logic port_float_option_i,
    input wire logic selected_indicator_o,
    input wire logic cascade_select_out_o,
    input wire logic interrupt_out_first_o,
    input wire logic interrupt_out_first_oe_o,
    input wire logic interrupt_out_second_o,
    input wire logic interrupt_out_second_oe_o,
    input wire logic irq_request_first_i,
    input wire logic irq_request_second_i,
    input wire logic port_drivers_enable_o,
    input wire logic failed_command_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // windows cover the two-stage synchroniser plus edge detect
    deselect_float_a: assert property ((select_in_first_i && select_in_second_i)[*8]
        |-> !serial_out_first_oe_o && !serial_out_second_oe_o) else $error("output driven while deselected");
    single_driver_a: assert property (!(serial_out_first_oe_o && serial_out_second_oe_o))
        else $error("both serial outputs driven");
    indicators_idle_a: assert property ((select_in_first_i && select_in_second_i)[*8]
        |-> selected_indicator_o && cascade_select_out_o) else $error("indicator low while deselected");
    cascade_quiet_a: assert property (!cascade_select_out_o
        |-> !serial_out_first_oe_o && !serial_out_second_oe_o) else $error("output driven after cascade");
    irq_pull_low_a: assert property (!interrupt_out_first_o && !interrupt_out_second_o)
        else $error("interrupt output drives high");
    irq_gate_a: assert property ((!port_enable_in_i)[*4]
        |-> !interrupt_out_first_oe_o && !interrupt_out_second_oe_o) else $error("interrupt while disabled");
    irq_follow_a: assert property ((port_enable_in_i && irq_request_first_i)[*4]
        |-> interrupt_out_first_oe_o) else $error("interrupt request not signalled");
    irq_cause_a: assert property (interrupt_out_second_oe_o |-> irq_request_second_i)
        else $error("interrupt without request");
    float_ports_a: assert property ((!port_enable_in_i && port_float_option_i)[*4]
        |-> !port_drivers_enable_o) else $error("ports driven while floated");
    drive_ports_a: assert property (port_enable_in_i[*5] |-> port_drivers_enable_o)
        else $error("ports floated while enabled");
    fail_pulse_a: assert property (failed_command_o |=> !failed_command_o)
        else $error("failed pulse longer than one cycle");
endmodule // dual_spi_slave_front_end_sva

bind dual_spi_slave_front_end dual_spi_slave_front_end_sva dual_spi_slave_front_end_sva_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .select_in_first_i(select_in_first_i),
    .select_in_second_i(select_in_second_i), .serial_out_first_oe_o(serial_out_first_oe_o),
    .serial_out_second_oe_o(serial_out_second_oe_o), .port_enable_in_i(port_enable_in_i),
    .port_float_option_i(port_float_option_i), .selected_indicator_o(selected_indicator_o),
    .cascade_select_out_o(cascade_select_out_o), .interrupt_out_first_o(interrupt_out_first_o),
    .interrupt_out_first_oe_o(interrupt_out_first_oe_o), .interrupt_out_second_o(interrupt_out_second_o),
    .interrupt_out_second_oe_o(interrupt_out_second_oe_o), .irq_request_first_i(irq_request_first_i),
    .irq_request_second_i(irq_request_second_i), .port_drivers_enable_o(port_drivers_enable_o),
    .failed_command_o(failed_command_o));

// ---- dual_spi_slave_front_end_tb.sv ----
`timescale 1ns/1ps
module dual_spi_slave_front_end_tb;
    logic       mclk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] tx_data = 8'h00;
    logic       tx_en = 1'b0;
    logic       rx_ready = 1'b1;
    logic       pe = 1'b1;
    logic       flt = 1'b0;
    logic [1:0] irq = 2'h0;
    logic       tag_ok = 1'b1;
    wire        sel_a_n, sck_a, sdi_a, out_a, oe_a, sel_b_n, sck_b, sdi_b, out_b, oe_b;
    wire        ind, cas, rxv, rxo, fail;
    wire [7:0]  rxd;
    // pulled-up data lines: a released output reads high
    wire        miso_a = oe_a ? out_a : 1'b1;
    wire        miso_b = oe_b ? out_b : 1'b1;
    int         error_cnt = 0;
    int         n_compared = 0;
    int         n_fail = 0;
    int         exp_fail = 0;
    int         seed = 32'h3bbc;
    logic [8:0] exp_q[$];
    logic [7:0] bq[$];
    logic [7:0] op, d;
    logic [9:0] want;

    spi_host_model host_first (.sel_n_o(sel_a_n), .sck_o(sck_a), .sdo_o(sdi_a), .sdi_i(miso_a));
    spi_host_model host_second (.sel_n_o(sel_b_n), .sck_o(sck_b), .sdo_o(sdi_b), .sdi_i(miso_b));
    dual_spi_slave_front_end dual_spi_slave_front_end_i (
        .mclk_i(mclk_i), .reset_i(reset_i),
        .select_in_first_i(sel_a_n), .serial_clock_first_i(sck_a), .serial_in_first_i(sdi_a),
        .serial_out_first_o(out_a), .serial_out_first_oe_o(oe_a),
        .select_in_second_i(sel_b_n), .serial_clock_second_i(sck_b), .serial_in_second_i(sdi_b),
        .serial_out_second_o(out_b), .serial_out_second_oe_o(oe_b),
        .slave_address_pins_i(addr), .port_enable_in_i(pe), .port_float_option_i(flt),
        .selected_indicator_o(ind), .cascade_select_out_o(cas),
        .interrupt_out_first_o(), .interrupt_out_first_oe_o(), .interrupt_out_second_o(),
        .interrupt_out_second_oe_o(), .irq_request_first_i(irq[0]), .irq_request_second_i(irq[1]),
        .port_drivers_enable_o(), .rx_valid_o(rxv), .rx_ready_i(rx_ready), .rx_data_o(rxd),
        .rx_is_opcode_o(rxo), .tx_data_i(tx_data), .tx_enable_i(tx_en), .failed_command_o(fail));

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pins(input logic ind_e, input logic cas_e);
        check({8'h00, ind, cas}, {8'h00, ind_e, cas_e});
    endtask
    task automatic check_count(input int got, input int exp);
        check(10'(got), 10'(exp));
    endtask
    task automatic xfer_on(input bit sec, input logic [7:0] b, input int half, input int bits);
        if (sec) host_second.xfer(b, half, bits);
        else host_first.xfer(b, half, bits);
    endtask
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one access; last byte may be cut short, indicators looked at before and after close
    task automatic access(input bit sec, input logic [7:0] b[$], input int last, input logic ind_e, cas_e);
        if (sec) host_second.open_frame();
        else host_first.open_frame();
        for (int i = 0; i < b.size(); i++) begin
            xfer_on(sec, b[i], 160, i == b.size() - 1 ? last : 8);
        end
        #400 check_pins(ind_e, cas_e);
        if (sec) host_second.close_frame();
        else host_first.close_frame();
        check_pins(1'b1, 1'b1);
    endtask

    // drain side: popped bytes against the model queue, failure pulses counted
    always @(posedge mclk_i) begin
        if (fail === 1'b1) n_fail++;
        if (rxv === 1'b1 && rx_ready) begin
            want = exp_q.size() ? {1'b0, exp_q.pop_front()} : 10'h3ff;
            check({1'b0, tag_ok ? rxo : 1'b0, rxd}, want);
        end
    end
    initial forever #20 mclk_i = ~mclk_i;
    // watchdog well beyond the expected run
    initial begin
        #1000000;
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        #1 reset_i = 1'b0;
        repeat (4) @(posedge mclk_i);
        // hardware addressing on both ports
        for (int p = 0; p < 2; p++) begin
            op = 8'($random(seed)) | 8'h01;
            d = 8'($random(seed));
            exp_q.push_back({1'b1, op});
            exp_q.push_back({1'b0, d});
            access(p[0], '{op, d}, 8, 1'b0, 1'b1);
        end
        // software addressing: match, mismatch, then a no-operation
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk_i) #1 addr = k ? 8'hff : 8'($random(seed)) | 8'h02;
            op = 8'($random(seed)) | 8'h01;
            d = 8'($random(seed));
            exp_q.push_back({1'b1, op});
            exp_q.push_back({1'b0, d});
            access(k[0], '{addr, op, d}, 8, 1'b0, 1'b1);
            access(k[0], '{addr ^ 8'h10, op, d}, 8, 1'b1, 1'b1);
            access(k[0], '{addr, 8'h00, d}, 8, 1'b0, 1'b0);
        end
        // select rises after three bits of a data byte
        @(posedge mclk_i) #1 addr = 8'h00;
        op = 8'($random(seed)) | 8'h01;
        exp_q.push_back({1'b1, op});
        exp_fail++;
        access(1'b0, '{op, 8'h5a}, 3, 1'b0, 1'b1);
        // first select stuck low, second port takes over
        exp_q.push_back({1'b1, 8'h11});
        host_first.open_frame();
        host_first.xfer(8'h11, 160, 8);
        op = 8'($random(seed)) | 8'h01;
        d = 8'($random(seed));
        exp_q.push_back({1'b1, op});
        exp_q.push_back({1'b0, d});
        access(1'b1, '{op, d}, 8, 1'b0, 1'b1);
        host_first.close_frame();
        // stalled drain: four bytes kept, the rest dropped
        @(posedge mclk_i) #1 rx_ready = 1'b0;
        tag_ok = 1'b0;
        op = 8'($random(seed)) | 8'h01;
        bq = '{op};
        exp_q.push_back({1'b0, op});
        for (int k = 0; k < 5; k++) begin
            bq.push_back(8'($random(seed)));
            if (k < 3) exp_q.push_back({1'b0, bq[k + 1]});
        end
        access(1'b0, bq, 8, 1'b0, 1'b1);
        @(posedge mclk_i) #1 rx_ready = 1'b1;
        repeat (20) @(posedge mclk_i);
        #1 tag_ok = 1'b1;
        check_count(exp_q.size(), 0);
        // readback on a slow clock on each port: two driven bytes, then a released line
        for (int p = 0; p < 2; p++) begin
            op = 8'($random(seed)) | 8'h01;
            exp_q.push_back({1'b1, op});
            if (p) host_second.open_frame();
            else host_first.open_frame();
            xfer_on(p[0], op, 480, 8);
            for (int k = 0; k < 3; k++) begin
                d = 8'($random(seed));
                exp_q.push_back({1'b0, d});
                @(posedge mclk_i) #1 tx_data = 8'($random(seed));
                tx_en = k < 2;
                xfer_on(p[0], d, 480, 8);
                check({2'h0, p ? host_second.got : host_first.got}, {2'h0, k < 2 ? tx_data : 8'hff});
            end
            if (p) host_second.close_frame();
            else host_first.close_frame();
        end
        // interrupt and port gating, then random levels
        @(posedge mclk_i) #1 {pe, flt, irq} = 4'h7;
        repeat (8) @(posedge mclk_i);
        #1 {pe, flt, irq} = 4'hb;
        repeat (8) @(posedge mclk_i);
        repeat (40) @(posedge mclk_i) #1 {pe, flt, irq} = 4'($random(seed));
        repeat (8) @(posedge mclk_i);
        check_count(n_fail, exp_fail);
        conclude();
    end
endmodule // dual_spi_slave_front_end_tb

// ---- spi_front_map.vh ----
`ifndef SPI_FRONT_MAP_VH
`define SPI_FRONT_MAP_VH

// opcode that triggers cascading
`define OPCODE_NO_OPERATION   8'h00
// bits in one byte
`define BITS_PER_BYTE         4'h8
// address value that selects hardware addressing
`define HARDWARE_ADDRESS      8'h00
// fifo geometry for received bytes
`define RX_FIFO_WIDTH         8
`define RX_FIFO_DEPTH         4
`define RX_FIFO_PTR_BITS      2
// sequencer states
`define ST_IDLE               3'h0
`define ST_ADDRESS            3'h1
`define ST_OPCODE             3'h2
`define ST_DATA               3'h3
`define ST_STANDBY            3'h4

`endif

// ---- spi_host_model.sv ----
`timescale 1ns/1ps
// behavioural mode-3 host on one serial port
module spi_host_model (
    // serial pins
    output logic       sel_n_o,
    output logic       sck_o,
    output logic       sdo_o,
    input  wire logic  sdi_i
);
    logic [7:0] got;
    // idle: deselected, clock parked high
    initial begin
        sel_n_o = 1'b1;
        sck_o   = 1'b1;
        sdo_o   = 1'b0;
        got     = 8'h00;
    end
    // host starts every access by a falling select
    task automatic open_frame();
        #200 sel_n_o = 1'b0;
        #200;
    endtask
    // msb first, data set while clock low, sampled just before the rise
    task automatic xfer(input logic [7:0] b, input int half, input int bits);
        for (int i = 7; i >= 8 - bits; i--) begin
            sck_o = 1'b0;
            sdo_o = b[i];
            #(half);
            got = {got[6:0], sdi_i};
            sck_o = 1'b1;
            #(half);
        end
        sdo_o = ~sdo_o; // released line never shows the last bit
    endtask
    task automatic close_frame();
        sel_n_o = 1'b1;
        #400;
    endtask
endmodule // spi_host_model
